/* logic/system_synth_control.sv */
/*
  System frequency synthesiser control register with unlock guard
  and divider/multiplier decode. Assumes configuration words are
  stable at power-on and the oscillator select comes from another
  clock domain, so it is synchronised here.
*/
// Chosen here: the address-and-strobe port and the address map.
// Notes on behaviour
// - Output divider codes 1..5 give divide 2..32; 0, 6, 7 reserved.
// - Multiplier factor is the seven-bit code plus one, 1 to 128.
// - Fields load from configuration words at power-on, not constants.
// - Writes need the unlock sequence; locked writes are ignored.
// - Writes are rejected while the synthesiser drives the system clock.
// - Unimplemented bits read zero and ignore writes.
`default_nettype none
module system_synth_control
(
  input  wire logic        i_mclk,
  input  wire logic        i_reset_n,
  input  wire logic [3:0]  i_addr,
  input  wire logic [31:0] i_wdata,
  input  wire logic        i_wr,
  input  wire logic        i_rd,
  output logic      [31:0] o_rdata,
  input  wire logic [31:0] i_device_config_word_two,
  input  wire logic [6:0]  i_config_other_fields,
  input  wire logic [2:0]  i_current_oscillator_select,
  output logic      [2:0]  o_synth_output_divider,
  output logic      [6:0]  o_synth_feedback_multiplier,
  output logic      [2:0]  o_synth_input_divider,
  output logic             o_synth_input_clock_select,
  output logic      [2:0]  o_synth_input_range,
  output logic      [5:0]  o_divide_ratio,
  output logic      [7:0]  o_multiply_factor,
  output logic             o_divider_reserved,
  output logic             o_unlocked,
  output logic             o_write_rejected
);
  typedef enum logic [2:0]
  {
    LOCKED  = 3'b001,
    HALF    = 3'b010,
    OPEN    = 3'b100
  } lock_state_t;

  lock_state_t lock_state;
  lock_state_t next_lock_state;
  logic [31:0] control;
  logic [31:0] next_control;
  logic        loaded;
  logic        next_loaded;
  logic        rejected;
  logic        next_rejected;
  logic [31:0] rdata;
  logic [31:0] next_rdata;
  logic [2:0]  osc_meta;
  logic [2:0]  osc_sync;
  logic        synth_active;
  logic        ctrl_wr;

  // Two-stage synchroniser for the oscillator select
  always_ff @(posedge i_mclk or negedge i_reset_n)
  begin
    if (!i_reset_n)
    begin
      osc_meta <= 3'h0;
      osc_sync <= 3'h0;
    end
    else
    begin
      osc_meta <= i_current_oscillator_select;
      osc_sync <= osc_meta;
    end
  end

  assign synth_active = (osc_sync == synth_ctrl_pkg::OSC_SYNTH);
  assign ctrl_wr = i_wr && (i_addr == synth_ctrl_pkg::REG_CONTROL_ADDR);

  // Unlock: two key words in a row; any other write between them relocks, except a repeated first key, which stays half open
  always_comb
  begin
    next_lock_state = lock_state;
    if (i_wr)
    begin
      if (i_addr == synth_ctrl_pkg::REG_UNLOCK_ADDR)
      begin
        if (i_wdata == synth_ctrl_pkg::UNLOCK_KEY_FIRST)
          next_lock_state = HALF;
        else if (i_wdata == synth_ctrl_pkg::UNLOCK_KEY_SECOND
                 && lock_state == HALF)
          next_lock_state = OPEN;
        else
          next_lock_state = LOCKED;
      end
      else if (lock_state == HALF)
        next_lock_state = LOCKED;
    end
  end

  property p_unlock_seq;
    @(posedge i_mclk) disable iff (!i_reset_n)
    (i_wr && i_addr == synth_ctrl_pkg::REG_UNLOCK_ADDR && lock_state == HALF
     && i_wdata == synth_ctrl_pkg::UNLOCK_KEY_SECOND) |=> lock_state == OPEN;
  endproperty
  a_unlock_seq: assert property (p_unlock_seq)
    else $error("Key pair did not unlock");

  // Any write but a key word to the unlock address after the first key throws the pair away
  property p_relock_other;
    @(posedge i_mclk) disable iff (!i_reset_n)
    (i_wr && lock_state == HALF
     && !(i_addr == synth_ctrl_pkg::REG_UNLOCK_ADDR
          && (i_wdata == synth_ctrl_pkg::UNLOCK_KEY_FIRST
              || i_wdata == synth_ctrl_pkg::UNLOCK_KEY_SECOND)))
    |=> lock_state == LOCKED;
  endproperty
  a_relock_other: assert property (p_relock_other)
    else $error("Broken key pair left lock half open");

  // Strap load happens after reset release, since async reset takes constants
  always_comb
  begin
    next_control  = control;
    next_loaded   = 1'b1;
    next_rejected = rejected;
    if (!loaded)
    begin
      next_control = 32'h0;
      next_control[26:24] =
        i_device_config_word_two[synth_ctrl_pkg::ODIV_LSB +: 3];
      next_control[22:16] =
        i_device_config_word_two[synth_ctrl_pkg::MULT_LSB +: 7];
      next_control[10:8] = i_config_other_fields[6:4];
      next_control[7]    = i_config_other_fields[3];
      next_control[2:0]  = i_config_other_fields[2:0];
    end
    else if (ctrl_wr)
    begin
      if (lock_state == OPEN && !synth_active)
      begin
        next_control = i_wdata & synth_ctrl_pkg::IMPL_MASK;
        next_rejected = 1'b0;
      end
      else
        next_rejected = 1'b1;
    end
  end

  always_comb
  begin
    next_rdata = 32'h0;
    if (i_rd)
    begin
      if (i_addr == synth_ctrl_pkg::REG_CONTROL_ADDR)
        next_rdata = control & synth_ctrl_pkg::IMPL_MASK;
      else if (i_addr == synth_ctrl_pkg::REG_MULT_ADDR)
        next_rdata = {24'h0, o_multiply_factor};
      else if (i_addr == synth_ctrl_pkg::REG_ODIV_ADDR)
        next_rdata = {25'h0, o_divider_reserved, o_divide_ratio};
      else if (i_addr == synth_ctrl_pkg::REG_UNLOCK_ADDR)
        next_rdata = {29'h0, rejected, synth_active, lock_state == OPEN};
      else
        next_rdata = 32'h0;
    end
  end

  property p_readback_zero;
    @(posedge i_mclk) disable iff (!i_reset_n)
    (i_rd && i_addr == synth_ctrl_pkg::REG_CONTROL_ADDR)
    |=> (o_rdata & ~synth_ctrl_pkg::IMPL_MASK) == 32'h0;
  endproperty
  a_readback_zero: assert property (p_readback_zero)
    else $error("Unimplemented bit read back as one");

  property p_readback_match;
    @(posedge i_mclk) disable iff (!i_reset_n)
    (i_rd && i_addr == synth_ctrl_pkg::REG_CONTROL_ADDR)
    |=> o_rdata == $past(control);
  endproperty
  a_readback_match: assert property (p_readback_match)
    else $error("Control read back differs from storage");

  always_ff @(posedge i_mclk or negedge i_reset_n)
  begin
    if (!i_reset_n)
    begin
      lock_state <= LOCKED;
      control    <= 32'h0;
      loaded     <= 1'b0;
      rejected   <= 1'b0;
      rdata      <= 32'h0;
    end
    else
    begin
      lock_state <= next_lock_state;
      control    <= next_control;
      loaded     <= next_loaded;
      rejected   <= next_rejected;
      rdata      <= next_rdata;
    end
  end

  // Decode: ratio 2^code for legal codes, zero when reserved
  always_comb
  begin
    o_divider_reserved = 1'b1;
    o_divide_ratio     = 6'h0;
    if (control[26:24] >= synth_ctrl_pkg::ODIV_MIN_CODE
        && control[26:24] <= synth_ctrl_pkg::ODIV_MAX_CODE)
    begin
      o_divider_reserved = 1'b0;
      o_divide_ratio = 6'(6'h01 << control[26:24]);
    end
  end

  assign o_multiply_factor = {1'b0, control[22:16]} + 8'h01;
  assign o_synth_output_divider      = control[26:24];
  assign o_synth_feedback_multiplier = control[22:16];
  assign o_synth_input_divider       = control[10:8];
  assign o_synth_input_clock_select  = control[7];
  assign o_synth_input_range         = control[2:0];
  assign o_unlocked       = (lock_state == OPEN);
  assign o_write_rejected = rejected;
  assign o_rdata          = rdata;

  property p_locked_write_ignored;
    @(posedge i_mclk) disable iff (!i_reset_n)
    (loaded && ctrl_wr && lock_state != OPEN) |=> $stable(control);
  endproperty
  a_locked_write_ignored: assert property (p_locked_write_ignored)
    else $error("Locked write changed control");

  property p_locked_write_flagged;
    @(posedge i_mclk) disable iff (!i_reset_n)
    (loaded && ctrl_wr && lock_state != OPEN) |=> rejected;
  endproperty
  a_locked_write_flagged: assert property (p_locked_write_flagged)
    else $error("Locked write not flagged");

  property p_busy_write_ignored;
    @(posedge i_mclk) disable iff (!i_reset_n)
    (loaded && ctrl_wr && synth_active) |=> $stable(control);
  endproperty
  a_busy_write_ignored: assert property (p_busy_write_ignored)
    else $error("Write accepted while synth active");

  property p_busy_write_flagged;
    @(posedge i_mclk) disable iff (!i_reset_n)
    (loaded && ctrl_wr && synth_active) |=> rejected;
  endproperty
  a_busy_write_flagged: assert property (p_busy_write_flagged)
    else $error("Write while synth active not flagged");

  property p_open_write_clears;
    @(posedge i_mclk) disable iff (!i_reset_n)
    (loaded && ctrl_wr && lock_state == OPEN && !synth_active) |=> !rejected;
  endproperty
  a_open_write_clears: assert property (p_open_write_clears)
    else $error("Accepted write left reject flag set");

  property p_fields_held;
    @(posedge i_mclk) disable iff (!i_reset_n)
    (loaded && !ctrl_wr) |=> $stable(control);
  endproperty
  a_fields_held: assert property (p_fields_held)
    else $error("Control changed without a write");

  property p_unimpl_zero;
    @(posedge i_mclk) disable iff (!i_reset_n)
    (control & ~synth_ctrl_pkg::IMPL_MASK) == 32'h0;
  endproperty
  a_unimpl_zero: assert property (p_unimpl_zero)
    else $error("Unimplemented bit set");

  property p_open_write;
    @(posedge i_mclk) disable iff (!i_reset_n)
    (loaded && ctrl_wr && lock_state == OPEN && !synth_active)
    |=> control == ($past(i_wdata) & synth_ctrl_pkg::IMPL_MASK);
  endproperty
  a_open_write: assert property (p_open_write)
    else $error("Unlocked write lost");

  property p_mult_factor;
    @(posedge i_mclk) disable iff (!i_reset_n)
    o_multiply_factor == {1'b0, control[22:16]} + 8'h01
    && (control[22:16] != 7'h7F || o_multiply_factor == 8'h80);
  endproperty
  a_mult_factor: assert property (p_mult_factor)
    else $error("Multiply factor wrong");

  property p_div_ratio;
    @(posedge i_mclk) disable iff (!i_reset_n)
    (control[26:24] == 3'h5 |-> o_divide_ratio == 6'h20)
    and (control[26:24] == 3'h1 |-> o_divide_ratio == 6'h02);
  endproperty
  a_div_ratio: assert property (p_div_ratio)
    else $error("Divide ratio wrong");

  property p_div_onehot;
    @(posedge i_mclk) disable iff (!i_reset_n)
    !o_divider_reserved |-> $onehot(o_divide_ratio) && !o_divide_ratio[0];
  endproperty
  a_div_onehot: assert property (p_div_onehot)
    else $error("Legal divider code gave no power of two");

  property p_div_reserved;
    @(posedge i_mclk) disable iff (!i_reset_n)
    (control[26:24] == 3'h0 || control[26:24] > 3'h5)
    |-> o_divider_reserved;
  endproperty
  a_div_reserved: assert property (p_div_reserved)
    else $error("Reserved code not flagged");

  property p_strap_load;
    @(posedge i_mclk) disable iff (!i_reset_n)
    !loaded |=> control[26:24] == $past(i_device_config_word_two[26:24])
    && control[22:16] == $past(i_device_config_word_two[22:16])
    && control[10:8] == $past(i_config_other_fields[6:4]);
  endproperty
  a_strap_load: assert property (p_strap_load)
    else $error("Power-on load wrong");
endmodule
`default_nettype wire

/* pkg/synth_ctrl_pkg.sv */
/*
  Constants for the system frequency synthesiser control register.
  Assumes a 32-bit control register plus multiplier, divider and unlock addresses over a plain strobe port.
*/
`default_nettype none
package synth_ctrl_pkg;
  localparam logic [3:0]  REG_CONTROL_ADDR   = 4'h0;
  localparam logic [3:0]  REG_MULT_ADDR      = 4'h4;
  localparam logic [3:0]  REG_ODIV_ADDR      = 4'h8;
  localparam logic [3:0]  REG_UNLOCK_ADDR    = 4'hC;
  localparam int          ODIV_LSB           = 24;
  localparam int          MULT_LSB           = 16;
  localparam int          IDIV_LSB           = 8;
  localparam int          ICLK_BIT           = 7;
  localparam int          RANGE_LSB          = 0;
  localparam logic [31:0] IMPL_MASK          = 32'h077F0787;
  localparam logic [2:0]  ODIV_MIN_CODE      = 3'h1;
  localparam logic [2:0]  ODIV_MAX_CODE      = 3'h5;
  localparam logic [2:0]  OSC_SYNTH          = 3'h1;
  localparam logic [31:0] UNLOCK_KEY_FIRST   = 32'hAA996655;
  localparam logic [31:0] UNLOCK_KEY_SECOND  = 32'h556699AA;
endpackage
`default_nettype wire

/* testbench/tb_top.sv */
/*
  Self-checking bench for the synthesiser control register.
  Assumes the design's strobe port, read data one cycle after i_rd.
*/
`default_nettype none
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  typedef struct packed
  {
    logic [31:0] wdata;
    logic [5:0]  ratio;
    logic [7:0]  factor;
    logic        rsv;
  } row_t;
  logic        i_mclk, i_reset_n, i_wr, i_rd, o_synth_input_clock_select;
  logic        o_divider_reserved, o_unlocked, o_write_rejected;
  logic [3:0]  i_addr;
  logic [31:0] i_wdata, o_rdata, i_device_config_word_two, seen;
  logic [6:0]  i_config_other_fields, o_synth_feedback_multiplier;
  logic [2:0]  i_current_oscillator_select, o_synth_output_divider;
  logic [2:0]  o_synth_input_divider, o_synth_input_range;
  logic [5:0]  o_divide_ratio;
  logic [7:0]  o_multiply_factor;
  int          err_total, check_count, cycles;
  row_t        rows [8] = '{
    '{32'hFFFFFFFF, 6'h00, 8'h80, 1'b1}, '{32'h01000000, 6'h02, 8'h01, 1'b0},
    '{32'h027E0000, 6'h04, 8'h7F, 1'b0}, '{32'h03000000, 6'h08, 8'h01, 1'b0},
    '{32'h04000000, 6'h10, 8'h01, 1'b0}, '{32'h05000000, 6'h20, 8'h01, 1'b0},
    '{32'h06000000, 6'h00, 8'h01, 1'b1}, '{32'h00000000, 6'h00, 8'h01, 1'b1}};
  system_synth_control i_dut
  (
    .i_mclk(i_mclk), .i_reset_n(i_reset_n), .i_addr(i_addr),
    .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata),
    .i_device_config_word_two(i_device_config_word_two),
    .i_config_other_fields(i_config_other_fields),
    .i_current_oscillator_select(i_current_oscillator_select),
    .o_synth_output_divider(o_synth_output_divider),
    .o_synth_feedback_multiplier(o_synth_feedback_multiplier),
    .o_synth_input_divider(o_synth_input_divider),
    .o_synth_input_clock_select(o_synth_input_clock_select),
    .o_synth_input_range(o_synth_input_range),
    .o_divide_ratio(o_divide_ratio), .o_multiply_factor(o_multiply_factor),
    .o_divider_reserved(o_divider_reserved), .o_unlocked(o_unlocked),
    .o_write_rejected(o_write_rejected)
  );
  initial
  begin
    i_mclk = 1'b0;
    forever #5 i_mclk = ~i_mclk;
  end
  task automatic chk(input string name, input logic [31:0] got, exp);
    check_count++;
    if (got !== exp)
    begin
      err_total++;
      $display("ERROR %s expected %h seen %h", name, exp, got);
    end
  endtask
  task automatic complete_run;
    $display("Mismatches %0d of %0d comparisons", err_total, check_count);
    if (err_total == 0 && check_count > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    @(posedge i_mclk);
    i_wr <= 1'b1; i_addr <= a; i_wdata <= d;
    @(posedge i_mclk);
    i_wr <= 1'b0;
    // Let the edge's register updates settle before anyone looks
    #1;
  endtask
  task automatic rd(input logic [3:0] a);
    @(posedge i_mclk);
    i_rd <= 1'b1; i_addr <= a;
    @(posedge i_mclk);
    i_rd <= 1'b0;
    #1 seen = o_rdata;
  endtask
  task automatic do_reset;
    i_reset_n <= 1'b0;
    repeat (12) @(posedge i_mclk);
    i_reset_n <= 1'b1;
    repeat (2) @(posedge i_mclk);
  endtask
  task automatic check_defaults;
    logic [31:0] c;
    logic [6:0]  o;
    c = i_device_config_word_two;
    o = i_config_other_fields;
    rd(4'h0);
    chk("reset readback", seen, {5'h00, c[26:24], 1'b0, c[22:16], 5'h00,
        o[6:4], o[3], 4'h0, o[2:0]});
    chk("odiv", 32'(o_synth_output_divider), 32'(c[26:24]));
    chk("mult", 32'(o_synth_feedback_multiplier), 32'(c[22:16]));
    chk("others", 32'({o_synth_input_divider, o_synth_input_clock_select,
        o_synth_input_range}), 32'(o));
    chk("reset lock", 32'(o_unlocked), 32'h0);
    chk("reset reject", 32'(o_write_rejected), 32'h0);
  endtask
  always @(posedge i_mclk)
  begin
    cycles <= cycles + 1;
    if (cycles == 2000)
    begin
      err_total++;
      complete_run();
    end
  end
  initial
  begin
    {i_wr, i_rd, i_addr, i_wdata, cycles, err_total, check_count} = '0;
    i_reset_n = 1'b0;
    i_device_config_word_two = 32'h03450000;
    i_config_other_fields = 7'h5A;
    i_current_oscillator_select = 3'h0;
    do_reset();
    check_defaults();
    // Locked write, then a broken key pair, must both be dropped
    wr(4'h0, 32'h01000000);
    chk("locked reject", 32'(o_write_rejected), 32'h1);
    wr(4'hC, synth_ctrl_pkg::UNLOCK_KEY_FIRST);
    wr(4'hC, 32'h12345678);
    wr(4'hC, synth_ctrl_pkg::UNLOCK_KEY_SECOND);
    chk("relocked", 32'(o_unlocked), 32'h0);
    wr(4'h0, 32'h01000000);
    rd(4'h0);
    chk("locked keep", seen, 32'h03450582);
    // A control write between the keys breaks the pair
    wr(4'hC, synth_ctrl_pkg::UNLOCK_KEY_FIRST);
    wr(4'h0, 32'h01000000);
    wr(4'hC, synth_ctrl_pkg::UNLOCK_KEY_SECOND);
    chk("split pair", 32'(o_unlocked), 32'h0);
    wr(4'hC, synth_ctrl_pkg::UNLOCK_KEY_FIRST);
    wr(4'hC, synth_ctrl_pkg::UNLOCK_KEY_SECOND);
    chk("unlocked", 32'(o_unlocked), 32'h1);
    foreach (rows[k])
    begin
      wr(4'h0, rows[k].wdata);
      rd(4'h0);
      chk("readback", seen,
          rows[k].wdata & synth_ctrl_pkg::IMPL_MASK);
      chk("ratio", 32'(o_divide_ratio), 32'(rows[k].ratio));
      chk("reserved", 32'(o_divider_reserved), 32'(rows[k].rsv));
      chk("factor", 32'(o_multiply_factor), 32'(rows[k].factor));
      chk("accepted", 32'(o_write_rejected), 32'h0);
      rd(4'h4);
      chk("factor read", seen, 32'(rows[k].factor));
      rd(4'h8);
      chk("ratio read", seen, 32'({rows[k].rsv, rows[k].ratio}));
    end
    rd(4'h2);
    chk("unmapped", seen, 32'h0);
    // Synthesiser driving the clock; wait out the two-stage sync
    i_current_oscillator_select <= synth_ctrl_pkg::OSC_SYNTH;
    repeat (4) @(posedge i_mclk);
    wr(4'h0, 32'h05000000);
    rd(4'h0);
    chk("osc keep", seen, 32'h0);
    chk("osc reject", 32'(o_write_rejected), 32'h1);
    rd(4'hC);
    chk("osc status", seen, 32'h7);
    i_current_oscillator_select <= 3'h0;
    i_device_config_word_two <= 32'h02120000;
    i_config_other_fields <= 7'h25;
    do_reset();
    check_defaults();
    complete_run();
  end
endmodule
`default_nettype wire
